// [core/ptmr_regs.svh]
// register offsets, field positions and reset values of the periodic timer
`ifndef PTMR_REGS_SVH
`define PTMR_REGS_SVH
// ------------------------------------------------------------
// byte offsets on the register bus
// ------------------------------------------------------------
`define PTMR_OFS_CTRL0   5'h00
`define PTMR_OFS_CTRL1   5'h04
`define PTMR_OFS_CNT_LO  5'h08
`define PTMR_OFS_CNT_HI  5'h0C
`define PTMR_OFS_CMPA_LO 5'h10
`define PTMR_OFS_CMPA_HI 5'h14
`define PTMR_OFS_PER_LO  5'h18
`define PTMR_OFS_PER_HI  5'h1C
// ------------------------------------------------------------
// field positions
// ------------------------------------------------------------
`define PTMR_C0_PAUSE    7
`define PTMR_C0_CKS_HI   6
`define PTMR_C0_CKS_LO   4
`define PTMR_C0_RUN      3
// ------------------------------------------------------------
// reset values and answers
// ------------------------------------------------------------
`define PTMR_RST_BYTE    8'h00
`define PTMR_RST_CNT     10'h000
`define PTMR_CNT_MAX     10'h3FF
`define PTMR_RESP_OKAY   2'h0
`define PTMR_RESP_SLVERR 2'h2
`endif

// [core/ptmr_pkg.sv]
// types shared by the periodic timer
package ptmr_pkg;
    // ------------------------------------------------------------
    // operating modes, in register encoding order
    // ------------------------------------------------------------
    typedef enum logic [1:0] {
        PTMR_MODE_CMP,
        PTMR_MODE_CAP,
        PTMR_MODE_PWM,
        PTMR_MODE_TMR
    } ptmr_mode_e;
    // ------------------------------------------------------------
    // second control register as fields
    // ------------------------------------------------------------
    typedef struct packed {
        ptmr_mode_e  mode;  // operating_mode_select
        logic [1:0]  fsel;  // output_function_select
        logic        oc;    // output_initial_level
        logic        pol;   // output_polarity_invert
        logic        cks;   // capture_source_select
        logic        cclr;  // counter_clear_select
    } ptmr_ctrl1_s;
endpackage : ptmr_pkg

// [core/ptmr_top.sv]
// periodic timer with its register set on an axi4-lite slave
//
// Decided for this implementation: register access over AXI4-Lite and the register addresses.
`timescale 1ns/1ps
`include "ptmr_regs.svh"
// Function
// - three-bit field selects counter clock source
// - run bit counts; clear stops and gates
// - run rise zeroes counter; fall holds it
// - run rise restores compare output level
// - unimplemented bits read as zero
// - two-bit field selects operating mode
// - timer/counter mode output level undefined
// - compare A match sets, clears, toggles
// - pwm mode: inactive, active, pwm, pulse
// - capture edge: rise, fall, both, off
// - requested equals initial: no visible change
// - initial level or active level per mode
// - polarity bit inverts output pins, except in timer mode
// - capture source: capture pin or clock pin
// - clear on match A, or P/overflow
// - overflow clear only when period zero
// - clear select ignored in pwm, capture
// - ten-bit counter readable, not writable
// - compare A ten bits, resets zero
// - period ten bits, resets zero
// - pause freezes counter, resume continues
// - ten-bit up-counter, two comparators
// - counter clears raise timer requests
module ptmr_top
    import ptmr_pkg::*;
(
    input  wire logic        sys_clk_i,
    input  wire logic        rst_n_i,
    // axi4-lite slave
    input  wire logic [4:0]  s_axi_awaddr_i,
    input  wire logic        s_axi_awvalid_i,
    output logic             s_axi_awready_o,
    input  wire logic [31:0] s_axi_wdata_i,
    input  wire logic [3:0]  s_axi_wstrb_i,
    input  wire logic        s_axi_wvalid_i,
    output logic             s_axi_wready_o,
    output logic [1:0]       s_axi_bresp_o,
    output logic             s_axi_bvalid_o,
    input  wire logic        s_axi_bready_i,
    input  wire logic [4:0]  s_axi_araddr_i,
    input  wire logic        s_axi_arvalid_i,
    output logic             s_axi_arready_o,
    output logic [31:0]      s_axi_rdata_o,
    output logic [1:0]       s_axi_rresp_o,
    output logic             s_axi_rvalid_o,
    input  wire logic        s_axi_rready_i,
    // clock sources and timer pins
    input  wire logic        high_speed_clock_i,
    input  wire logic        time_base_clock_i,
    input  wire logic        external_clock_pin_i,
    input  wire logic        capture_input_pin_i,
    output logic             timer_output_pin_o,
    output logic             timer_output_pin_complement_o,
    output logic             match_a_request_o,
    output logic             match_p_request_o
);
    // ------------------------------------------------------------
    // functions
    // ------------------------------------------------------------
    // pick an edge event by a two-bit edge kind
    function automatic logic pick_edge(input logic rise,
                                       input logic fall,
                                       input logic [1:0] kind);
        case (kind)
            2'h0:    pick_edge = rise;
            2'h1:    pick_edge = fall;
            2'h2:    pick_edge = rise | fall;
            default: pick_edge = 1'b0;
        endcase
    endfunction : pick_edge

    // output level from active flag and active-level bit
    function automatic logic act_level(input logic active,
                                       input logic oc);
        act_level = active ? oc : ~oc;
    endfunction : act_level

    // ------------------------------------------------------------
    // registers
    // ------------------------------------------------------------
    logic [7:0]  ctrl0_reg;      // pause, clock select, run
    ptmr_ctrl1_s ctrl1_reg;      // mode and output control
    logic [9:0]  cmpa_reg;       // compare_a_value
    logic [9:0]  per_reg;        // period_compare_value
    logic [9:0]  cnt_reg;        // the counter
    logic        run_d_reg;      // run bit one cycle ago
    logic        out_reg;        // compare-mode output state
    logic [1:0]  div4_reg;       // system clock by four
    logic [5:0]  hdiv_reg;       // high-speed clock divider
    logic [3:0]  s1_reg;         // pin sync stage one
    logic [3:0]  s2_reg;         // pin sync stage two
    logic [3:0]  s3_reg;         // pin sync stage three
    logic [3:0]  filt_reg;       // agreed pin levels
    logic        aw_got_reg;     // write address held
    logic        w_got_reg;      // write data held
    logic [4:0]  awaddr_reg;     // held write address
    logic [7:0]  wbyte_reg;      // held write byte
    logic        wen_reg;        // byte lane zero enabled
    logic        awready_reg;
    logic        wready_reg;
    logic        bvalid_reg;
    logic [1:0]  bresp_reg;
    logic        arready_reg;
    logic        rvalid_reg;
    logic [31:0] rdata_reg;
    logic [1:0]  rresp_reg;
    logic        pin_reg;        // true output pin
    logic        pinb_reg;       // complement output pin
    logic        mreqa_reg;      // match A request pulse
    logic        mreqp_reg;      // match P request pulse

    // ------------------------------------------------------------
    // pin synchronisers and edge detection
    // ------------------------------------------------------------
    // bit 0 clock pin, 1 capture pin, 2 high-speed, 3 time base
    wire logic [3:0] pins_w = {time_base_clock_i, high_speed_clock_i,
                               capture_input_pin_i, external_clock_pin_i};
    // a new level counts only once stages two and three agree
    wire logic [3:0] filt_next = (s2_reg & s3_reg)
                               | (filt_reg & (s2_reg | s3_reg));
    wire logic [3:0] rise_w = filt_next & ~filt_reg;
    wire logic [3:0] fall_w = ~filt_next & filt_reg;

    // three-stage synchroniser
    always_ff @(posedge sys_clk_i) begin
        if (!rst_n_i) begin
            s1_reg   <= 4'h0;
            s2_reg   <= 4'h0;
            s3_reg   <= 4'h0;
            filt_reg <= 4'h0;
        end else begin
            s1_reg   <= pins_w;
            s2_reg   <= s1_reg;
            s3_reg   <= s2_reg;
            filt_reg <= filt_next;
        end
    end

    // ------------------------------------------------------------
    // control decode
    // ------------------------------------------------------------
    wire logic       run_w    = ctrl0_reg[`PTMR_C0_RUN];
    wire logic       pause_w  = ctrl0_reg[`PTMR_C0_PAUSE];
    wire logic [2:0] cksel_w  = ctrl0_reg[`PTMR_C0_CKS_HI:`PTMR_C0_CKS_LO];
    wire ptmr_mode_e mode_w   = ctrl1_reg.mode;
    wire logic       run_rise = run_w & ~run_d_reg;
    wire logic       is_cmp   = (mode_w == PTMR_MODE_CMP);
    wire logic       is_tmr   = (mode_w == PTMR_MODE_TMR);
    wire logic       is_cap   = (mode_w == PTMR_MODE_CAP);
    wire logic       is_pwm   = (mode_w == PTMR_MODE_PWM);
    wire logic       is_spl   = is_pwm & (ctrl1_reg.fsel == 2'h3);

    // ------------------------------------------------------------
    // counter clock source
    // ------------------------------------------------------------
    wire logic tick_div4 = (div4_reg == 2'h3);
    wire logic tick_h16  = rise_w[2] & (hdiv_reg[3:0] == 4'hF);
    wire logic tick_h64  = rise_w[2] & (hdiv_reg == 6'h3F);
    logic      src_tick;         // selected clock tick
    // clock source multiplexer
    always_comb begin
        case (cksel_w)
            3'h0:    src_tick = tick_div4;
            3'h1:    src_tick = 1'b1;
            3'h2:    src_tick = tick_h16;
            3'h3:    src_tick = tick_h64;
            3'h4:    src_tick = rise_w[3];
            3'h5:    src_tick = rise_w[3];
            3'h6:    src_tick = rise_w[0];
            default: src_tick = fall_w[0];
        endcase
    end
    // counting needs run set and pause clear
    wire logic tick_w = src_tick & run_w & ~pause_w;

    // prescalers, held in reset while the timer is off
    always_ff @(posedge sys_clk_i) begin
        if (!rst_n_i || !run_w) begin
            div4_reg <= 2'h0;
            hdiv_reg <= 6'h00;
        end else begin
            div4_reg <= div4_reg + 2'h1;
            if (rise_w[2]) begin
                hdiv_reg <= hdiv_reg + 6'h01;
            end
        end
    end

    // ------------------------------------------------------------
    // comparators
    // ------------------------------------------------------------
    wire logic [9:0] cnt_inc = cnt_reg + 10'h001;
    // match A when the next count reaches compare A, zero excluded
    wire logic hit_a = tick_w & (cnt_inc == cmpa_reg)
                     & (cmpa_reg != 10'h000);
    // match P at the period; a zero period means overflow
    wire logic ovf_w = (cnt_reg == `PTMR_CNT_MAX);
    wire logic hit_p = tick_w & ((per_reg == 10'h000) ? ovf_w
                                 : (cnt_inc == per_reg));
    // clear select only matters in compare and timer modes
    wire logic clr_cm  = ctrl1_reg.cclr ? hit_a : hit_p;
    wire logic clr_w   = (is_cmp | is_tmr) ? clr_cm
                       : (is_spl ? 1'b0 : hit_p);
    // match A requests outside capture mode; match P requests unless A clears or in single pulse
    wire logic req_a_w = hit_a & ~(is_cap);
    wire logic req_p_w = hit_p & ~((is_cmp | is_tmr) & ctrl1_reg.cclr)
                       & ~is_spl;

    // ------------------------------------------------------------
    // capture trigger
    // ------------------------------------------------------------
    wire logic cap_rise = ctrl1_reg.cks ? rise_w[0] : rise_w[1];
    wire logic cap_fall = ctrl1_reg.cks ? fall_w[0] : fall_w[1];
    wire logic cap_w    = is_cap & run_w
                        & pick_edge(cap_rise, cap_fall,
                                    ctrl1_reg.fsel);

    // counter, cleared by a run rising edge, held when stopped
    always_ff @(posedge sys_clk_i) begin
        if (!rst_n_i) begin
            cnt_reg <= `PTMR_RST_CNT;
        end else if (run_rise) begin
            cnt_reg <= `PTMR_RST_CNT;
        end else if (clr_w) begin
            cnt_reg <= `PTMR_RST_CNT;
        end else if (tick_w) begin
            cnt_reg <= cnt_inc;
        end
    end

    // ------------------------------------------------------------
    // output generation
    // ------------------------------------------------------------
    // compare-mode output state
    always_ff @(posedge sys_clk_i) begin
        if (!rst_n_i) begin
            out_reg <= 1'b0;
        end else if (run_rise) begin
            out_reg <= ctrl1_reg.oc;
        end else if (is_cmp && hit_a) begin
            case (ctrl1_reg.fsel)
                2'h1:    out_reg <= 1'b0;  // equal level stays
                2'h2:    out_reg <= 1'b1;
                2'h3:    out_reg <= ~out_reg;
                default: out_reg <= out_reg;
            endcase
        end
    end
    // pwm duty: active below compare A, full when A not below a nonzero period
    wire logic duty_w = (cnt_reg < cmpa_reg)
                      | ((per_reg != 10'h000) && (cmpa_reg >= per_reg));
    logic pwm_act;               // active flag in pwm family
    // pwm and single pulse function select
    always_comb begin
        case (ctrl1_reg.fsel)
            2'h0:    pwm_act = 1'b0;
            2'h1:    pwm_act = 1'b1;
            2'h2:    pwm_act = duty_w & run_w;
            default: pwm_act = run_w;
        endcase
    end
    logic lvl_w;                 // output level before polarity
    // level per mode
    always_comb begin
        case (mode_w)
            PTMR_MODE_CMP: lvl_w = out_reg;
            PTMR_MODE_PWM: lvl_w = act_level(pwm_act, ctrl1_reg.oc);
            default:       lvl_w = 1'b0;
        endcase
    end
    wire logic pin_next = lvl_w ^ (ctrl1_reg.pol & ~is_tmr);

    // pins and request pulses from flops
    always_ff @(posedge sys_clk_i) begin
        if (!rst_n_i) begin
            pin_reg   <= 1'b0;
            pinb_reg  <= 1'b1;
            mreqa_reg <= 1'b0;
            mreqp_reg <= 1'b0;
        end else begin
            pin_reg   <= pin_next;
            pinb_reg  <= ~pin_next;
            mreqa_reg <= req_a_w;
            mreqp_reg <= req_p_w;
        end
    end

    // ------------------------------------------------------------
    // axi4-lite write path
    // ------------------------------------------------------------
    wire logic aw_fire  = s_axi_awvalid_i & awready_reg;
    wire logic w_fire   = s_axi_wvalid_i & wready_reg;
    wire logic do_wr    = aw_got_reg & w_got_reg;
    wire logic wr_map   = (awaddr_reg[1:0] == 2'h0);
    wire logic wr_ok    = do_wr & wr_map & wen_reg;
    wire logic wsel_c0  = wr_ok & (awaddr_reg == `PTMR_OFS_CTRL0);
    wire logic wsel_c1  = wr_ok & (awaddr_reg == `PTMR_OFS_CTRL1);
    wire logic wsel_al  = wr_ok & (awaddr_reg == `PTMR_OFS_CMPA_LO);
    wire logic wsel_ah  = wr_ok & (awaddr_reg == `PTMR_OFS_CMPA_HI);
    wire logic wsel_pl  = wr_ok & (awaddr_reg == `PTMR_OFS_PER_LO);
    wire logic wsel_ph  = wr_ok & (awaddr_reg == `PTMR_OFS_PER_HI);
    // single pulse: clock pin edge sets run, match A clears it
    wire logic sp_set   = is_spl & ~run_w & rise_w[0];
    wire logic sp_clr   = is_spl & hit_a;

    // handshake of address and data, either order
    always_ff @(posedge sys_clk_i) begin
        if (!rst_n_i) begin
            aw_got_reg  <= 1'b0;
            w_got_reg   <= 1'b0;
            awaddr_reg  <= 5'h00;
            wbyte_reg   <= 8'h00;
            wen_reg     <= 1'b0;
            awready_reg <= 1'b0;
            wready_reg  <= 1'b0;
            bvalid_reg  <= 1'b0;
            bresp_reg   <= `PTMR_RESP_OKAY;
        end else begin
            if (aw_fire) begin
                aw_got_reg <= 1'b1;
                awaddr_reg <= s_axi_awaddr_i;
            end else if (do_wr) begin
                aw_got_reg <= 1'b0;
            end
            if (w_fire) begin
                w_got_reg <= 1'b1;
                wbyte_reg <= s_axi_wdata_i[7:0];
                wen_reg   <= s_axi_wstrb_i[0];
            end else if (do_wr) begin
                w_got_reg <= 1'b0;
            end
            awready_reg <= ~(aw_got_reg | aw_fire) & ~bvalid_reg & ~do_wr;
            wready_reg  <= ~(w_got_reg | w_fire) & ~bvalid_reg & ~do_wr;
            if (do_wr) begin
                bvalid_reg <= 1'b1;
                bresp_reg  <= (wr_map && awaddr_reg <= `PTMR_OFS_PER_HI)
                            ? `PTMR_RESP_OKAY : `PTMR_RESP_SLVERR;
            end else if (s_axi_bready_i) begin
                bvalid_reg <= 1'b0;
            end
        end
    end

    // register file; counter offsets take no write
    always_ff @(posedge sys_clk_i) begin
        if (!rst_n_i) begin
            ctrl0_reg <= `PTMR_RST_BYTE;
            ctrl1_reg <= ptmr_ctrl1_s'(`PTMR_RST_BYTE);
            cmpa_reg  <= 10'h000;
            per_reg   <= 10'h000;
            run_d_reg <= 1'b0;
        end else begin
            run_d_reg <= run_w;
            if (wsel_c0) begin
                ctrl0_reg <= {wbyte_reg[7:3], 3'h0};
            end else if (sp_set) begin
                ctrl0_reg[`PTMR_C0_RUN] <= 1'b1;
            end else if (sp_clr) begin
                ctrl0_reg[`PTMR_C0_RUN] <= 1'b0;
            end
            if (wsel_c1) begin
                ctrl1_reg <= ptmr_ctrl1_s'(wbyte_reg);
            end
            if (wsel_al) begin
                cmpa_reg[7:0] <= wbyte_reg;
            end else if (wsel_ah) begin
                cmpa_reg[9:8] <= wbyte_reg[1:0];
            end else if (cap_w) begin
                cmpa_reg <= cnt_reg;
            end
            if (wsel_pl) begin
                per_reg[7:0] <= wbyte_reg;
            end else if (wsel_ph) begin
                per_reg[9:8] <= wbyte_reg[1:0];
            end
        end
    end

    // ------------------------------------------------------------
    // axi4-lite read path
    // ------------------------------------------------------------
    wire logic ar_fire = s_axi_arvalid_i & arready_reg;
    logic [7:0] rd_byte;         // selected register
    logic       rd_hit;          // address is mapped
    // read decode, upper bits zero
    always_comb begin
        rd_hit = (s_axi_araddr_i[1:0] == 2'h0);
        case (s_axi_araddr_i)
            `PTMR_OFS_CTRL0:   rd_byte = ctrl0_reg;
            `PTMR_OFS_CTRL1:   rd_byte = ctrl1_reg;
            `PTMR_OFS_CNT_LO:  rd_byte = cnt_reg[7:0];
            `PTMR_OFS_CNT_HI:  rd_byte = {6'h00, cnt_reg[9:8]};
            `PTMR_OFS_CMPA_LO: rd_byte = cmpa_reg[7:0];
            `PTMR_OFS_CMPA_HI: rd_byte = {6'h00, cmpa_reg[9:8]};
            `PTMR_OFS_PER_LO:  rd_byte = per_reg[7:0];
            `PTMR_OFS_PER_HI:  rd_byte = {6'h00, per_reg[9:8]};
            default: begin
                rd_byte = 8'h00;
                rd_hit  = 1'b0;
            end
        endcase
    end

    // one read at a time
    always_ff @(posedge sys_clk_i) begin
        if (!rst_n_i) begin
            arready_reg <= 1'b0;
            rvalid_reg  <= 1'b0;
            rdata_reg   <= 32'h0000_0000;
            rresp_reg   <= `PTMR_RESP_OKAY;
        end else begin
            arready_reg <= ~rvalid_reg & ~ar_fire;
            if (ar_fire) begin
                rvalid_reg <= 1'b1;
                rdata_reg  <= {24'h000000, rd_byte};
                rresp_reg  <= rd_hit ? `PTMR_RESP_OKAY : `PTMR_RESP_SLVERR;
            end else if (s_axi_rready_i) begin
                rvalid_reg <= 1'b0;
            end
        end
    end

    // ------------------------------------------------------------
    // outputs
    // ------------------------------------------------------------
    assign s_axi_awready_o = awready_reg;
    assign s_axi_wready_o  = wready_reg;
    assign s_axi_bvalid_o  = bvalid_reg;
    assign s_axi_bresp_o   = bresp_reg;
    assign s_axi_arready_o = arready_reg;
    assign s_axi_rvalid_o  = rvalid_reg;
    assign s_axi_rdata_o   = rdata_reg;
    assign s_axi_rresp_o   = rresp_reg;
    assign timer_output_pin_o            = pin_reg;
    assign timer_output_pin_complement_o = pinb_reg;
    assign match_a_request_o = mreqa_reg;
    assign match_p_request_o = mreqp_reg;
endmodule : ptmr_top

// [tb/ptmr_pin_model.sv]
// pin model: drives the timer's clock and capture pins
`timescale 1ns/1ps
module ptmr_pin_model (
    input  wire logic clk_i,
    output logic      ext_pin_o,
    output logic      cap_pin_o,
    output logic      base_clk_o
);
    logic [3:0] div_reg = 4'h0;  // free divider, pins swing slowly
    // edges far apart so the design's input synchroniser sees each one
    always_ff @(posedge clk_i) begin
        div_reg <= div_reg + 4'h1;
    end
    assign ext_pin_o = div_reg[3];  // one rising edge every sixteen cycles
    assign cap_pin_o = div_reg[2];
    assign base_clk_o = div_reg[1];  // clock-like input, one rise every four cycles
endmodule : ptmr_pin_model

// [tb/ptmr_top_chk.sv]
// bus and pin checker bound to the timer top
`timescale 1ns/1ps
module ptmr_chk (
    input wire logic        sys_clk_i,
    input wire logic        rst_n_i,
    input wire logic        s_axi_awvalid_i,
    input wire logic        s_axi_awready_o,
    input wire logic        s_axi_wvalid_i,
    input wire logic        s_axi_wready_o,
    input wire logic        s_axi_bvalid_o,
    input wire logic        s_axi_bready_i,
    input wire logic        s_axi_arvalid_i,
    input wire logic        s_axi_arready_o,
    input wire logic [31:0] s_axi_rdata_o,
    input wire logic        s_axi_rvalid_o,
    input wire logic        s_axi_rready_i,
    input wire logic        timer_output_pin_o,
    input wire logic        timer_output_pin_complement_o
);
    default clocking cb @(posedge sys_clk_i); endclocking
    default disable iff (!rst_n_i);
    pin_compl_a: assert property (timer_output_pin_o ^ timer_output_pin_complement_o)
        else $error("complement pin not inverse");
    rdata_upper_a: assert property (s_axi_rvalid_o |-> s_axi_rdata_o[31:8] == 24'h0)
        else $error("read data upper bits set");
    rd_answer_a: assert property (s_axi_arvalid_i && s_axi_arready_o |=> s_axi_rvalid_o)
        else $error("read answer late");
    wr_answer_a: assert property (s_axi_awvalid_i && s_axi_awready_o && s_axi_wvalid_i
        && s_axi_wready_o |-> ##[1:2] s_axi_bvalid_o) else $error("write answer late");
    rd_release_a: assert property (s_axi_rvalid_o && s_axi_rready_i |=> !s_axi_rvalid_o)
        else $error("rvalid held after handshake");
    wr_release_a: assert property (s_axi_bvalid_o && s_axi_bready_i |=> !s_axi_bvalid_o)
        else $error("bvalid held after handshake");
    wr_busy_a: assert property (s_axi_bvalid_o |-> !s_axi_awready_o && !s_axi_wready_o)
        else $error("write ready during response");
    rd_busy_a: assert property (s_axi_rvalid_o |-> !s_axi_arready_o)
        else $error("read ready during response");
    cover property (s_axi_bvalid_o && s_axi_bready_i);
    cover property (s_axi_rvalid_o && s_axi_rready_i);
    cover property ($rose(timer_output_pin_o));
endmodule : ptmr_chk
bind ptmr_top ptmr_chk i_chk (.*);

// [tb/ptmr_top_tb.sv]
// self-checking bench for the periodic timer
`timescale 1ns/1ps
module ptmr_top_tb;
    logic        clk = 0, rst_n = 0, awv = 0, wv = 0, br = 0, arv = 0, rr = 0;
    logic [4:0]  awa = 5'h00, ara = 5'h00;
    logic [31:0] wd = 32'h0, rdat, q, r;
    logic [1:0]  rresp, rsp;
    logic        awr, wrd, bv, arr, rv, pin, pinb, ext, cap, fclk, mra, mrp;
    int          err_count = 0, compares = 0, seed = 32'hF279, i, n, m, regm [8] = '{default: 0};
    int          msk [8] = '{8'hF8, 8'hFF, 0, 0, 8'hFF, 8'h03, 8'hFF, 8'h03};
    int          lo [8] = '{25, 102, 1, 0, 24, 24, 5, 5};
    int          hi [8] = '{27, 104, 1, 0, 27, 27, 7, 7};
    logic [9:0]  tab [10] = '{10'h000, 10'h040, 10'h081, 10'h0C1, 10'h0B0, 10'h092,
                              10'h220, 10'h263, 10'h2A2, 10'h300};
    initial forever #20 clk = ~clk;
    ptmr_top i_dut (.sys_clk_i(clk), .rst_n_i(rst_n), .s_axi_awaddr_i(awa),
        .s_axi_awvalid_i(awv), .s_axi_awready_o(awr), .s_axi_wdata_i(wd),
        .s_axi_wstrb_i(4'hF), .s_axi_wvalid_i(wv), .s_axi_wready_o(wrd),
        .s_axi_bresp_o(), .s_axi_bvalid_o(bv), .s_axi_bready_i(br),
        .s_axi_araddr_i(ara), .s_axi_arvalid_i(arv), .s_axi_arready_o(arr),
        .s_axi_rdata_o(rdat), .s_axi_rresp_o(rresp), .s_axi_rvalid_o(rv),
        .s_axi_rready_i(rr), .high_speed_clock_i(fclk), .time_base_clock_i(fclk),
        .external_clock_pin_i(ext), .capture_input_pin_i(cap), .timer_output_pin_o(pin),
        .timer_output_pin_complement_o(pinb), .match_a_request_o(mra), .match_p_request_o(mrp));
    ptmr_pin_model i_pins (.clk_i(clk), .ext_pin_o(ext), .cap_pin_o(cap), .base_clk_o(fclk));
    // compare one value and count it
    task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
        compares++;
        if (got !== exp) begin
            err_count++;
            $display("MISMATCH %s expected %h seen %h", nm, exp, got);
        end
    endtask : chk
    // bus write of register k, model follows with its access mask
    task automatic wrm(input int k, input logic [7:0] d);
        @(posedge clk);
        awa <= 5'(k * 4);
        wd <= {24'h0, d};
        awv <= 1'b1;
        wv <= 1'b1;
        br <= 1'b1;
        do begin
            @(posedge clk);
            if (awr) awv <= 1'b0;
            if (wrd) wv <= 1'b0;
        end while (!bv);
        br <= 1'b0;
        regm[k] = d & msk[k];
    endtask : wrm
    // bus read, data and response kept
    task automatic rd(input logic [4:0] a, output logic [31:0] d);
        @(posedge clk);
        ara <= a;
        arv <= 1'b1;
        rr <= 1'b1;
        do begin
            @(posedge clk);
            if (arr) arv <= 1'b0;
        end while (!rv);
        d = rdat;
        rsp = rresp;
        rr <= 1'b0;
    endtask : rd
    task automatic complete_run;
        $display("mismatches %0d compares %0d", err_count, compares);
        if (err_count == 0 && compares > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask : complete_run
    initial begin
        repeat (30000) @(posedge clk);
        err_count++;
        complete_run;
    end
    initial begin
        repeat (12) @(posedge clk);
        rst_n <= 1'b1;
        for (i = 0; i < 8; i++) begin
            rd(5'(i * 4), q);
            chk("reset", regm[i], q);
        end
        wrm(0, 8'hF7);
        // mode bit 7 kept low: single pulse would set run from the clock pin
        for (i = 1; i < 8; i++) wrm(i, 8'($random(seed)) & (i == 1 ? 8'h7F : 8'hFF));
        for (i = 0; i < 8; i++) begin
            rd(5'(i * 4), q);
            chk("regs", regm[i], q);
        end
        for (i = 1; i < 8; i++) wrm(i, 8'h00);
        // every clock source, run, freeze, restart from zero
        for (i = 0; i < 8; i++) begin
            wrm(0, 8'(i * 16 + 8));
            repeat (100) @(posedge clk);
            wrm(0, 8'(i * 16 + 8'h88));
            rd(5'h08, q);
            rd(5'h08, r);
            chk("count", 1, q >= lo[i] && q <= hi[i] && r == q);
            wrm(0, 8'h00);
        end
        wrm(6, 8'h05);
        wrm(0, 8'h18);
        for (i = 0; i < 6; i++) begin
            rd(5'h08, q);
            chk("period", 1, q < 5);
        end
        wrm(4, 8'h20);
        wrm(6, 8'h00);
        // output pin per mode, function, level and polarity
        for (i = 0; i < 10; i++) begin
            wrm(0, 8'h00);
            wrm(1, tab[i][9:2]);
            wrm(0, 8'h18);
            repeat (4) @(posedge clk);
            chk("pin early", tab[i][1], pin);
            repeat (60) @(posedge clk);
            chk("pin late", tab[i][0], pin);
        end
        rd(5'h02, q);
        chk("unmapped", 32'h2, q | rsp);
        // capture keeps copying the frozen count into compare A
        wrm(0, 8'h00);
        wrm(1, 8'h40);
        wrm(0, 8'h18);
        repeat (40) @(posedge clk);
        wrm(0, 8'h98);
        repeat (12) @(posedge clk);
        rd(5'h08, q);
        rd(5'h10, r);
        chk("capture", q, r);
        // single pulse: clock pin edge starts it, match A at four ends it
        wrm(0, 8'h00);
        wrm(4, 8'h04);
        wrm(0, 8'h10);
        wrm(1, 8'hB8);
        repeat (16) @(posedge clk);
        n = 0;
        m = 0;
        repeat (64) begin
            @(posedge clk);
            n += pin;
            m += mra + 8 * mrp;
        end
        chk("pulse", 1, n >= 16 && n <= 24);
        chk("requests", 4, m);
        complete_run;
    end
endmodule : ptmr_top_tb
